//--- pkg/pdm_pkg.sv
// Package: constants and types for the power-down mode controller
package pdm_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    // Clock period in picoseconds (250 MHz)
    localparam int MCLK_PERIOD_PS = 4000;
    // Shortest settling time in states; one state is one mclk cycle
    localparam int SETTLE_BASE_STATES = 8192;
    // Settling count in cycles, derived from states and clock
    localparam int SETTLE_BASE_CYCLES = SETTLE_BASE_STATES * 4000
        / MCLK_PERIOD_PS;
    // Largest settling select, the codes above it are prohibited
    localparam logic [2:0] STS_MAX = 3'h4;
    // Width of the settling counter (131072 fits)
    localparam int SETTLE_CNT_W = 18;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Standby-select bit after reset: sleep is chosen
    localparam logic SEL_BIT_RESET = 1'b0;
    // Settling select after reset
    localparam logic [2:0] STS_RESET = 3'h0;
    // Synchronised pin level after reset (pins idle high)
    localparam logic PIN_IDLE = 1'b1;

    // ------------------------------------------------------------
    // External interrupt lines able to end software standby
    // ------------------------------------------------------------
    localparam logic [7:0] SW_WAKE_IRQ_MASK = 8'h47;

    // ------------------------------------------------------------
    // Power states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PDM_RESET,
        PDM_RUN,
        PDM_SLEEP,
        PDM_SWSTBY,
        PDM_SETTLE,
        PDM_HWSTBY
    } pdm_state_t;

endpackage

//--- pkg/pdm_settle_if.sv
// Interface: settling timer request and completion between modules
`timescale 1ns/1ps
interface pdm_settle_if;
    // Load and start the timer, one-cycle pulse
    logic start;
    // Stop the timer without completion
    logic abort;
    // Settling select, taken with start
    logic [2:0] sel;
    // Settling time elapsed, one-cycle pulse
    logic done;

    // Controller end
    modport ctrl (output start, output abort, output sel, input done);
    // Timer end
    modport timer (input start, input abort, input sel, output done);
endinterface

//--- verilog/pdm_settle.sv
// Settling timer for recovery from software standby
`timescale 1ns/1ps
module pdm_settle #(
    parameter int SETTLE_BASE = pdm_pkg::SETTLE_BASE_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Request and completion
    pdm_settle_if.timer st
);

    // ------------------------------------------------------------
    // Limit from select
    // ------------------------------------------------------------
    // Prohibited codes clamp to the longest time, the safe side
    function automatic logic [pdm_pkg::SETTLE_CNT_W-1:0] limit_of(
        input logic [2:0] s
    );
        logic [2:0] k;
        logic [pdm_pkg::SETTLE_CNT_W-1:0] b;
        k = (s > pdm_pkg::STS_MAX) ? pdm_pkg::STS_MAX : s;
        b = SETTLE_BASE[pdm_pkg::SETTLE_CNT_W-1:0];
        return b << k;
    endfunction

    // Remaining cycles
    logic [pdm_pkg::SETTLE_CNT_W-1:0] cnt_q, cnt_d;
    // Timer running
    logic busy_q, busy_d;
    // Completion pulse
    logic done_q, done_d;

    // Next values of the counter
    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (st.start) begin
            // Start wins over a stale abort
            cnt_d = limit_of(st.sel) - 1'b1;
            busy_d = 1'b1;
        end else if (st.abort) begin
            busy_d = 1'b0;
        end else if (busy_q) begin
            if (cnt_q == '0) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 1'b1;
            end
        end
    end

    // Register the counter
    always_ff @(posedge mclk) begin
        if (srst) begin
            cnt_q <= '0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign st.done = done_q;

    // Done only ever follows a running count
    settle_done_a: assert property (@(posedge mclk) disable iff (srst)
        done_q |-> $past(busy_q))
        else $error("settle done without running timer");

endmodule

//--- verilog/pdm_top.sv
// Power-down mode controller: sleep, software and hardware standby
`timescale 1ns/1ps
module pdm_top #(
    // Shortest settling count; shorten for simulation
    parameter int SETTLE_BASE = pdm_pkg::SETTLE_BASE_CYCLES
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic srst,
    // Pins from the system, asynchronous
    input wire logic hw_standby_pin_n,
    input wire logic reset_pin_n,
    // Processor side
    input wire logic sleep_exec,
    input wire logic ctrl_wr,
    input wire logic sel_bit_wr_data,
    input wire logic [2:0] sts_wr_data,
    // Interrupt requests, same clock
    input wire logic irq_any,
    input wire logic nmi_req,
    input wire logic [7:0] ext_irq,
    // Control bits as seen by software
    output logic standby_select_bit,
    output logic [2:0] settle_select,
    // Chip-wide controls
    output logic clock_run,
    output logic cpu_halt,
    output logic data_transfer_unit_run,
    output logic periph_run,
    output logic periph_init,
    output logic cpu_reg_clear,
    output logic port_hiz,
    output logic chip_reset,
    output logic wake_irq,
    // Mode indication
    output logic in_sleep,
    output logic in_sw_standby,
    output logic in_hw_standby
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // First stages, read only by the second stages
    logic sbpin_s1_q, rst_s1_q;
    // Second stages, safe to use
    logic sbpin_s2_q, rst_s2_q;

    // Two flops per pin; pins idle high under reset
    always_ff @(posedge mclk) begin
        if (srst) begin
            sbpin_s1_q <= pdm_pkg::PIN_IDLE;
            sbpin_s2_q <= pdm_pkg::PIN_IDLE;
            rst_s1_q <= pdm_pkg::PIN_IDLE;
            rst_s2_q <= pdm_pkg::PIN_IDLE;
        end else begin
            sbpin_s1_q <= hw_standby_pin_n;
            sbpin_s2_q <= sbpin_s1_q;
            rst_s1_q <= reset_pin_n;
            rst_s2_q <= rst_s1_q;
        end
    end

    // Pin conditions after synchronisation
    logic sbpin_low, rst_low;
    assign sbpin_low = !sbpin_s2_q;
    assign rst_low = !rst_s2_q;

    // ------------------------------------------------------------
    // Settling timer
    // ------------------------------------------------------------
    pdm_settle_if st_if ();

    pdm_settle #(
        .SETTLE_BASE(SETTLE_BASE)
    ) u_settle (
        .mclk(mclk),
        .srst(srst),
        .st(st_if.timer)
    );

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    // Output bits per state, in the order of the output ports
    function automatic logic [10:0] ctl_of(input pdm_pkg::pdm_state_t s);
        logic slp, sw, hw, rs;
        slp = s == pdm_pkg::PDM_SLEEP;
        // Settling counts as standby: only the oscillator runs
        sw = s == pdm_pkg::PDM_SWSTBY || s == pdm_pkg::PDM_SETTLE;
        hw = s == pdm_pkg::PDM_HWSTBY;
        rs = s == pdm_pkg::PDM_RESET;
        return {!(sw || hw),
            slp || sw || hw || rs,
            !(sw || hw || rs), !(sw || hw || rs),
            sw || hw || rs,
            hw, hw, rs, slp, sw, hw};
    endfunction
    // Registered controls; decoding the next state keeps the timing
    logic [10:0] ctl_q, ctl_d;

    // ------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------
    pdm_pkg::pdm_state_t state_q, state_d;
    // Software control bits
    logic sel_bit_q, sel_bit_d;
    logic [2:0] sts_q, sts_d;
    // Timer start request
    logic start_q, start_d;
    // One-cycle interrupt-handling start
    logic wake_q, wake_d;
    // Software standby wake source
    logic sw_wake;
    assign sw_wake = nmi_req || |(ext_irq & pdm_pkg::SW_WAKE_IRQ_MASK);

    // Next state and control bits
    always_comb begin
        state_d = state_q;
        sel_bit_d = sel_bit_q;
        sts_d = sts_q;
        wake_d = 1'b0;
        // Software writes only take effect while running
        if (ctrl_wr && state_q == pdm_pkg::PDM_RUN) begin
            sel_bit_d = sel_bit_wr_data;
            sts_d = sts_wr_data;
        end
        if (sbpin_low) begin
            // Standby pin wins over all, even from sleep
            state_d = pdm_pkg::PDM_HWSTBY;
        end else begin
            case (state_q)
                pdm_pkg::PDM_RESET: begin
                    // Held in reset until the reset pin rises
                    if (!rst_low) begin
                        state_d = pdm_pkg::PDM_RUN;
                    end
                end
                pdm_pkg::PDM_RUN: begin
                    if (rst_low) begin
                        state_d = pdm_pkg::PDM_RESET;
                    end else if (sleep_exec) begin
                        // Select bit picks the mode
                        state_d = sel_bit_q ? pdm_pkg::PDM_SWSTBY
                                         : pdm_pkg::PDM_SLEEP;
                    end
                end
                pdm_pkg::PDM_SLEEP: begin
                    if (rst_low) begin
                        state_d = pdm_pkg::PDM_RESET;
                    end else if (irq_any || nmi_req) begin
                        state_d = pdm_pkg::PDM_RUN;
                        wake_d = 1'b1;
                    end
                end
                pdm_pkg::PDM_SWSTBY: begin
                    if (rst_low) begin
                        state_d = pdm_pkg::PDM_RESET;
                    end else if (sw_wake) begin
                        // Oscillator must settle before running
                        state_d = pdm_pkg::PDM_SETTLE;
                    end
                end
                pdm_pkg::PDM_SETTLE: begin
                    if (rst_low) begin
                        state_d = pdm_pkg::PDM_RESET;
                    end else if (st_if.done) begin
                        // Select bit left set on purpose
                        state_d = pdm_pkg::PDM_RUN;
                        wake_d = 1'b1;
                    end
                end
                pdm_pkg::PDM_HWSTBY: begin
                    // Pin released: leave through reset state
                    state_d = pdm_pkg::PDM_RESET;
                end
                default: begin
                    state_d = pdm_pkg::PDM_RESET;
                end
            endcase
        end
        // Control register reinitialised by reset and hw standby
        if (state_d == pdm_pkg::PDM_RESET ||
            state_d == pdm_pkg::PDM_HWSTBY) begin
            sel_bit_d = pdm_pkg::SEL_BIT_RESET;
            sts_d = pdm_pkg::STS_RESET;
        end
        start_d = state_d == pdm_pkg::PDM_SETTLE &&
                  state_q != pdm_pkg::PDM_SETTLE;
        ctl_d = ctl_of(state_d);
    end

    // Register state and control bits
    always_ff @(posedge mclk) begin
        if (srst) begin
            state_q <= pdm_pkg::PDM_RESET;
            sel_bit_q <= pdm_pkg::SEL_BIT_RESET;
            ctl_q <= ctl_of(pdm_pkg::PDM_RESET);
            sts_q <= pdm_pkg::STS_RESET;
            start_q <= 1'b0;
            wake_q <= 1'b0;
        end else begin
            state_q <= state_d;
            sel_bit_q <= sel_bit_d;
            ctl_q <= ctl_d;
            sts_q <= sts_d;
            start_q <= start_d;
            wake_q <= wake_d;
        end
    end

    // Timer runs only while settling
    assign st_if.start = start_q;
    assign st_if.abort = state_q != pdm_pkg::PDM_SETTLE;
    assign st_if.sel = sts_q;

    // ------------------------------------------------------------
    // Outputs, each straight from a register
    // ------------------------------------------------------------
    assign {clock_run, cpu_halt, data_transfer_unit_run, periph_run,
        periph_init, cpu_reg_clear, port_hiz, chip_reset, in_sleep,
        in_sw_standby, in_hw_standby} = ctl_q;
    assign wake_irq = wake_q;
    assign standby_select_bit = sel_bit_q;
    assign settle_select = sts_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    hw_entry_a: assert property (
        sbpin_low |=> state_q == pdm_pkg::PDM_HWSTBY && port_hiz)
        else $error("standby pin low did not enter hw standby");
    hw_outputs_a: assert property (
        in_hw_standby |-> !clock_run && cpu_reg_clear && periph_init
            && port_hiz && !data_transfer_unit_run)
        else $error("hw standby controls wrong");
    sleep_outputs_a: assert property (
        in_sleep |-> clock_run && cpu_halt && periph_run
            && data_transfer_unit_run && !port_hiz && !cpu_reg_clear)
        else $error("sleep controls wrong");
    sw_outputs_a: assert property (
        in_sw_standby |-> !clock_run && cpu_halt && periph_init
            && !periph_run && !port_hiz && !cpu_reg_clear)
        else $error("software standby controls wrong");
    sleep_pick_a: assert property (
        state_q == pdm_pkg::PDM_RUN && sleep_exec && !sbpin_low && !rst_low
        |=> ($past(sel_bit_q) ? in_sw_standby : in_sleep))
        else $error("sleep instruction took wrong mode");
    sw_enter_a: assert property (
        state_q == pdm_pkg::PDM_RUN && sleep_exec && sel_bit_q
            && !sbpin_low && !rst_low |=> !clock_run)
        else $error("software standby not entered");
    sleep_wake_a: assert property (
        in_sleep && irq_any && !sbpin_low && !rst_low
        |=> state_q == pdm_pkg::PDM_RUN && wake_irq ##1 !wake_irq)
        else $error("interrupt did not end sleep");
    sleep_to_hw_a: assert property (
        in_sleep && sbpin_low |=> in_hw_standby)
        else $error("sleep did not go to hw standby");
    select_keep_a: assert property (
        state_q == pdm_pkg::PDM_SETTLE && st_if.done && !sbpin_low
            && !rst_low |=> standby_select_bit && wake_irq)
        else $error("select bit lost on standby recovery");
    sw_wake_a: assert property (
        state_q == pdm_pkg::PDM_SWSTBY && !sw_wake && !rst_low
            && !sbpin_low |=> state_q == pdm_pkg::PDM_SWSTBY)
        else $error("software standby left without wake source");
    hw_exit_a: assert property (
        in_hw_standby && !sbpin_low |=> chip_reset)
        else $error("hw standby did not exit through reset");

    sleep_cycle_c: cover property (
        in_sleep ##1 state_q == pdm_pkg::PDM_RUN && wake_irq);
    sw_cycle_c: cover property (
        state_q == pdm_pkg::PDM_SETTLE ##1 wake_irq);
    hw_cycle_c: cover property (in_sleep ##1 in_hw_standby);

endmodule

//--- testbench/pdm_pins.sv
// Model of the system logic that drives the standby and reset pins
`timescale 1ns/1ps
module pdm_pins (
    // Requests from the bench
    input wire logic hold_req,
    input wire logic boot_req,
    input wire logic slow,
    // Pins into the device, active low
    output logic hw_standby_pin_n,
    output logic reset_pin_n
);
    // ------------------------------------------------------------
    // Pin drivers
    // ------------------------------------------------------------
    // Both pins idle high from time zero
    initial begin
        hw_standby_pin_n = 1'b1;
        reset_pin_n = 1'b1;
    end

    // Pins move off the clock edge, as a board driver would
    // Slow mode mimics a lazy supervisor chip
    always @(hold_req) begin
        hw_standby_pin_n <= #(slow ? 7.3 : 1.3) ~hold_req;
    end

    // Reset pin cannot end hardware standby; the standby pin wins over it
    always @(boot_req) begin
        reset_pin_n <= #(slow ? 5.7 : 0.9) ~boot_req;
    end
endmodule

//--- testbench/tb.sv
// Self-checking testbench for the power-down mode controller
`timescale 1ns/1ps
module tb;
    // ------------------------------------------------------------
    // Expected control vectors per mode
    // ------------------------------------------------------------
    localparam int BASE = 4; // Short settling base
    localparam logic [10:0] M_RUN = 11'h580;
    localparam logic [10:0] M_SLP = 11'h784;
    localparam logic [10:0] M_SWS = 11'h242;
    localparam logic [10:0] M_HW = 11'h271;
    localparam logic [10:0] M_RST = 11'h648;

    // One ordinary case: control write, wake lines, wake expected
    typedef struct packed {
        logic sel_sw;
        logic [2:0] sel;
        logic irq;
        logic nmi;
        logic [7:0] ext;
        logic wakes;
    } pdm_row_t;

    // Rows: sleep wakes, every standby wake line, a prohibited
    // select, two ignored lines
    pdm_row_t rows [10] = '{
        '{1'b0, 3'h0, 1'b1, 1'b0, 8'h00, 1'b1},
        '{1'b0, 3'h0, 1'b0, 1'b1, 8'h00, 1'b1},
        '{1'b1, 3'h0, 1'b0, 1'b1, 8'h00, 1'b1},
        '{1'b1, 3'h1, 1'b0, 1'b0, 8'h01, 1'b1},
        '{1'b1, 3'h2, 1'b0, 1'b0, 8'h02, 1'b1},
        '{1'b1, 3'h3, 1'b0, 1'b0, 8'h04, 1'b1},
        '{1'b1, 3'h4, 1'b0, 1'b0, 8'h40, 1'b1},
        '{1'b1, 3'h7, 1'b0, 1'b0, 8'h04, 1'b1},
        '{1'b1, 3'h0, 1'b0, 1'b0, 8'h08, 1'b0},
        '{1'b1, 3'h0, 1'b1, 1'b0, 8'h00, 1'b0}
    };

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic hold_req = 1'b0; // Ask for standby pin low
    logic boot_req = 1'b0; // Ask for reset pin low
    logic slow = 1'b0;
    logic hw_standby_pin_n, reset_pin_n;
    logic sleep_exec = 1'b0, ctrl_wr = 1'b0, sel_bit_wr_data = 1'b0;
    logic [2:0] sts_wr_data = 3'h0;
    logic irq_any = 1'b0, nmi_req = 1'b0;
    logic [7:0] ext_irq = 8'h00;
    logic standby_select_bit, clock_run, cpu_halt, periph_run;
    logic data_transfer_unit_run, periph_init, cpu_reg_clear;
    logic port_hiz, chip_reset, wake_irq, in_sleep;
    logic in_sw_standby, in_hw_standby;
    logic [2:0] settle_select;
    logic [10:0] mode_v;
    int error_cnt = 0, checks_done = 0, cyc = 0, n, lim;

    assign mode_v = {clock_run, cpu_halt, data_transfer_unit_run,
        periph_run, periph_init, cpu_reg_clear, port_hiz, chip_reset,
        in_sleep, in_sw_standby, in_hw_standby};

    // Clock of 4 ns
    always #2 mclk = ~mclk;

    // ------------------------------------------------------------
    // Device and pin partner
    // ------------------------------------------------------------
    pdm_top #(.SETTLE_BASE(BASE)) dut_u (.mclk(mclk), .srst(srst),
        .hw_standby_pin_n(hw_standby_pin_n), .reset_pin_n(reset_pin_n),
        .sleep_exec(sleep_exec), .ctrl_wr(ctrl_wr),
        .sel_bit_wr_data(sel_bit_wr_data), .sts_wr_data(sts_wr_data),
        .irq_any(irq_any), .nmi_req(nmi_req), .ext_irq(ext_irq),
        .standby_select_bit(standby_select_bit),
        .settle_select(settle_select), .clock_run(clock_run),
        .cpu_halt(cpu_halt),
        .data_transfer_unit_run(data_transfer_unit_run),
        .periph_run(periph_run), .periph_init(periph_init),
        .cpu_reg_clear(cpu_reg_clear), .port_hiz(port_hiz),
        .chip_reset(chip_reset), .wake_irq(wake_irq),
        .in_sleep(in_sleep), .in_sw_standby(in_sw_standby),
        .in_hw_standby(in_hw_standby));

    pdm_pins pins_u (.hold_req(hold_req), .boot_req(boot_req),
        .slow(slow), .hw_standby_pin_n(hw_standby_pin_n),
        .reset_pin_n(reset_pin_n));

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic miss(input string what);
        error_cnt++;
        $display("MISMATCH t=%0t %s", $time, what);
    endtask

    task automatic chk_mode(input logic [10:0] exp, input string what);
        checks_done++;
        if (mode_v !== exp) miss(what);
    endtask

    task automatic chk_bit(input logic got, exp, input string what);
        checks_done++;
        if (got !== exp) miss(what);
    endtask

    task automatic chk_sel(input logic [2:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) miss(what);
    endtask

    task automatic chk_cnt(input int got, lo, hi, input string what);
        checks_done++;
        if (got < lo || got > hi) miss(what);
    endtask

    // Step k edges and sample once outputs settle
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge mclk);
            #1;
        end
    endtask

    // Control write, one cycle pulse
    task automatic wr_ctrl(input logic s, input logic [2:0] t);
        @(posedge mclk);
        ctrl_wr <= 1'b1;
        sel_bit_wr_data <= s;
        sts_wr_data <= t;
        tick(1);
        ctrl_wr <= 1'b0;
    endtask

    // Sleep instruction, one cycle pulse
    task automatic do_sleep;
        @(posedge mclk);
        sleep_exec <= 1'b1;
        tick(1);
        sleep_exec <= 1'b0;
    endtask

    // Bounded wait for a mode, then compare
    task automatic wait_mode(input logic [10:0] exp, input string what);
        for (int i = 0; i < 14 && mode_v !== exp; i++) tick(1);
        chk_mode(exp, what);
    endtask

    // Count cycles until the wake pulse, bounded
    task automatic wait_wake(output int k);
        k = 0;
        while (wake_irq !== 1'b1 && k < 400) begin
            tick(1);
            k++;
        end
    endtask

    // Enter run (0), sleep (1) or software standby (2)
    task automatic enter(input int k);
        if (k > 0) begin
            wr_ctrl(k == 2, 3'h0);
            do_sleep();
        end
    endtask

    // ------------------------------------------------------------
    // Timeout: whole run is far below this ceiling
    // ------------------------------------------------------------
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            miss("timeout");
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        #1;
        chk_mode(M_RST, "reset state");
        chk_bit(standby_select_bit, 1'b0, "select reset");
        chk_sel(settle_select, 3'h0, "settle reset");
        wait_mode(M_RUN, "run after reset");
        $display("test reset done");
        foreach (rows[i]) begin
            wr_ctrl(rows[i].sel_sw, rows[i].sel);
            chk_bit(standby_select_bit, rows[i].sel_sw, "select");
            chk_sel(settle_select, rows[i].sel, "settle select");
            do_sleep();
            chk_mode(rows[i].sel_sw ? M_SWS : M_SLP, "enter");
            @(posedge mclk);
            irq_any <= rows[i].irq;
            nmi_req <= rows[i].nmi;
            ext_irq <= rows[i].ext;
            #1;
            if (!rows[i].wakes) begin
                tick(12);
                chk_mode(M_SWS, "ignored wake");
                @(posedge mclk);
                nmi_req <= 1'b1;
                #1;
            end
            wait_wake(n);
            // Prohibited selects settle for the longest time
            lim = BASE << ((rows[i].sel > pdm_pkg::STS_MAX)
                ? pdm_pkg::STS_MAX : rows[i].sel);
            if (rows[i].sel_sw)
                chk_cnt(n, lim, lim + 6, "settle");
            else
                chk_cnt(n, 1, 2, "sleep wake");
            chk_mode(M_RUN, "after wake");
            chk_bit(standby_select_bit, rows[i].sel_sw, "kept");
            @(posedge mclk);
            irq_any <= 1'b0;
            nmi_req <= 1'b0;
            ext_irq <= 8'h00;
            #1;
            chk_bit(wake_irq, 1'b0, "wake pulse");
            if (rows[i].sel_sw) wr_ctrl(1'b0, 3'h0);
            $display("test row %0d done", i);
        end
        // Standby pin from each mode, writes refused while asleep
        for (int k = 0; k < 3; k++) begin
            slow <= k[0];
            enter(k);
            wr_ctrl(1'b1, 3'h3);
            chk_bit(standby_select_bit, k != 1, "write gate");
            hold_req <= 1'b1;
            wait_mode(M_HW, "hw standby");
            chk_bit(standby_select_bit, 1'b0, "bits lost");
            chk_sel(settle_select, 3'h0, "select lost");
            nmi_req <= 1'b1;
            ext_irq <= 8'h47;
            tick(10);
            chk_mode(M_HW, "irq ignored");
            nmi_req <= 1'b0;
            ext_irq <= 8'h00;
            hold_req <= 1'b0;
            wait_mode(M_RST, "hw exit");
            wait_mode(M_RUN, "run again");
            $display("test hw standby %0d done", k);
        end
        // Reset pin out of sleep and software standby
        for (int k = 1; k < 3; k++) begin
            enter(k);
            boot_req <= 1'b1;
            wait_mode(M_RST, "reset pin");
            chk_bit(standby_select_bit, 1'b0, "select cleared");
            boot_req <= 1'b0;
            wait_mode(M_RUN, "run again");
            $display("test reset pin %0d done", k);
        end
        close_out();
    end
endmodule
